// file: src/traverse_frequency_generator.sv
`timescale 1ns/100ps
`default_nettype none
module traverse_frequency_generator
#(
   parameter int tick_cyc = traverse_pkg::TICK_CYC
)
(
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wr_data,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic      [15:0] rd_data,
   input  wire logic [15:0] ramp_freq,
   input  wire logic [3:0]  hs_in,
   output logic             hs_out,
   output logic      [15:0] freq_out,
   output logic      [17:0] traverse_out,
   output logic             active
);

   logic [1:0]           mode;
   logic [15:0]          accel_time;
   logic [15:0]          decel_time;
   logic [15:0]          ampl;
   logic [15:0]          step;
   logic [1:0]           hs_src;
   logic [15:0]          ref_freq;
   logic [15:0]          fmin;
   logic [15:0]          fmax;
   traverse_pkg::state_t state;
   logic                 dir_up;
   logic signed [17:0]   offset;
   logic signed [17:0]   lim;
   logic signed [17:0]   jump;
   logic [40:0]          acc;
   logic                 hs_edge;
   logic                 running;
   logic                 is_slave;
   logic [40:0]          thr;
   logic [40:0]          next_acc;
   logic                 at_limit;
   logic signed [18:0]   sum;

   function automatic logic [15:0] pct_of(input logic [15:0] f,
                                          input logic [15:0] p);
      logic [31:0] prod;
      prod   = f * p;
      pct_of = 16'(prod / traverse_pkg::PCT_FULL);
   endfunction

   function automatic logic [15:0] clip(input logic [15:0] v,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
      clip = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   handshake_sync u_hs
   (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .hs_in   (hs_in),
      .hs_src  (hs_src),
      .hs_edge (hs_edge)
   );

   assign running  = (state == traverse_pkg::ST_RAMP) ||
                     (state == traverse_pkg::ST_HOLD);
   assign is_slave = (mode == traverse_pkg::MODE_SLAVE);

   // mode stays writable so software can always stop the traverse
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         mode <= traverse_pkg::MODE_OFF;
      else if (wr_en && addr == traverse_pkg::REG_MODE && wr_data[15:2] == 14'h0
               && wr_data[1:0] != 2'h3)
         mode <= wr_data[1:0];
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         accel_time <= traverse_pkg::RST_ACCEL;
         decel_time <= traverse_pkg::RST_DECEL;
         ampl       <= traverse_pkg::RST_AMPL;
         step       <= traverse_pkg::RST_STEP;
         hs_src     <= traverse_pkg::RST_HS_SRC;
         ref_freq   <= traverse_pkg::RST_REF;
         fmin       <= traverse_pkg::RST_FMIN;
         fmax       <= traverse_pkg::RST_FMAX;
      end
      else if (wr_en && !running)
      begin
         case (addr)
            traverse_pkg::REG_ACCEL:
               accel_time <= clip(wr_data, traverse_pkg::TIME_MIN,
                                  traverse_pkg::TIME_MAX);
            traverse_pkg::REG_DECEL:
               decel_time <= clip(wr_data, traverse_pkg::TIME_MIN,
                                  traverse_pkg::TIME_MAX);
            traverse_pkg::REG_AMPL:
               ampl <= clip(wr_data, 16'h0001, traverse_pkg::PCT_MAX);
            traverse_pkg::REG_STEP:
               step <= clip(wr_data, 16'h0001, traverse_pkg::PCT_MAX);
            traverse_pkg::REG_HS_SRC: hs_src   <= wr_data[1:0];
            traverse_pkg::REG_REF:    ref_freq <= wr_data;
            traverse_pkg::REG_FMIN:   fmin     <= wr_data;
            traverse_pkg::REG_FMAX:   fmax     <= wr_data;
            default:                  ;
         endcase
      end
   end

   // dda: one offset count per cycle at most, exact slope over time
   always_comb
   begin
      thr      = 41'((dir_up ? accel_time : decel_time) * 41'(tick_cyc));
      next_acc = acc + 41'({lim, 1'b0});
      at_limit = dir_up ? (offset >= lim) : (offset <= -lim);
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state  <= traverse_pkg::ST_IDLE;
         dir_up <= 1'b1;
         offset <= 18'sh0;
         lim    <= 18'sh0;
         jump   <= 18'sh0;
         acc    <= 41'h0;
         hs_out <= 1'b0;
      end
      else if (mode == traverse_pkg::MODE_OFF)
      begin
         state  <= traverse_pkg::ST_IDLE;
         offset <= 18'sh0;
         acc    <= 41'h0;
      end
      else
      begin
         case (state)
            traverse_pkg::ST_IDLE:
               state <= traverse_pkg::ST_WAIT_REF;
            traverse_pkg::ST_WAIT_REF:
               if (ramp_freq == ref_freq)
               begin
                  state  <= traverse_pkg::ST_RAMP;
                  lim    <= 18'(pct_of(ref_freq, ampl));
                  jump   <= 18'(pct_of(ref_freq, step));
                  dir_up <= !is_slave;
                  offset <= 18'sh0;
                  acc    <= 41'h0;
               end
            traverse_pkg::ST_RAMP:
               if ((is_slave && hs_edge) || (!is_slave && at_limit))
               begin
                  dir_up <= !dir_up;
                  offset <= dir_up ? offset - jump : offset + jump;
                  acc    <= 41'h0;
                  if (!is_slave)
                     hs_out <= !hs_out;
               end
               else if (at_limit)
                  state <= traverse_pkg::ST_HOLD;
               else if (next_acc >= thr)
               begin
                  acc    <= next_acc - thr;
                  offset <= dir_up ? offset + 18'sh1 : offset - 18'sh1;
               end
               else
                  acc <= next_acc;
            traverse_pkg::ST_HOLD:
               if (!is_slave || hs_edge)
               begin
                  state  <= traverse_pkg::ST_RAMP;
                  dir_up <= !dir_up;
                  offset <= dir_up ? offset - jump : offset + jump;
                  acc    <= 41'h0;
               end
            default:
               state <= traverse_pkg::ST_IDLE;
         endcase
      end
   end

   assign sum = 19'($signed({3'b000, ramp_freq})) + 19'(offset);

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         freq_out     <= 16'h0000;
         traverse_out <= 18'h00000;
         active       <= 1'b0;
      end
      else
      begin
         active       <= running;
         traverse_out <= running ? offset : 18'h00000;
         if (!running)
            freq_out <= ramp_freq;
         else if (sum < $signed({3'b000, fmin}))
            freq_out <= fmin;
         else if (sum > $signed({3'b000, fmax}))
            freq_out <= fmax;
         else
            freq_out <= sum[15:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         rd_data <= 16'h0000;
      else if (rd_en)
      begin
         case (addr)
            traverse_pkg::REG_MODE:   rd_data <= {14'h0, mode};
            traverse_pkg::REG_ACCEL:  rd_data <= accel_time;
            traverse_pkg::REG_DECEL:  rd_data <= decel_time;
            traverse_pkg::REG_AMPL:   rd_data <= ampl;
            traverse_pkg::REG_STEP:   rd_data <= step;
            traverse_pkg::REG_HS_SRC: rd_data <= {14'h0, hs_src};
            traverse_pkg::REG_REF:    rd_data <= ref_freq;
            traverse_pkg::REG_FMIN:   rd_data <= fmin;
            traverse_pkg::REG_FMAX:   rd_data <= fmax;
            traverse_pkg::REG_STATUS:
               rd_data <= {12'h0, hs_out, dir_up, 2'(state)};
            traverse_pkg::REG_OFFSET: rd_data <= offset[15:0];
            traverse_pkg::REG_FOUT:   rd_data <= freq_out;
            default:                  rd_data <= 16'h0000;
         endcase
      end
      else
         rd_data <= 16'h0000;
   end

endmodule // traverse_frequency_generator
`default_nettype wire

// file: src/traverse_pkg.sv
// How it works
// - triangle offset, separate rise and fall times
// - master ramps to amplitude then reverses
// - proportional jump at every reversal
// - master toggles handshake output at reversal
// - slave slope mirrors master, opposite sign
// - slave holds at limit awaiting handshake
// - slave reverses at once on handshake
// - offset summed into ramp_freq input
// - mode 0 off, 1 master, 2 slave
// - start only after reference first reached
// - settings other than mode locked while traverse runs
// - result clamped between minimum and maximum while running; idle output follows ramp_freq unclamped
// - handshake source chosen by setting
package traverse_pkg;

   // register indices on the plain port
   localparam logic [3:0] REG_MODE    = 4'h0;
   localparam logic [3:0] REG_ACCEL   = 4'h1;
   localparam logic [3:0] REG_DECEL   = 4'h2;
   localparam logic [3:0] REG_AMPL    = 4'h3;
   localparam logic [3:0] REG_STEP    = 4'h4;
   localparam logic [3:0] REG_HS_SRC  = 4'h5;
   localparam logic [3:0] REG_REF     = 4'h6;
   localparam logic [3:0] REG_FMIN    = 4'h7;
   localparam logic [3:0] REG_FMAX    = 4'h8;
   localparam logic [3:0] REG_STATUS  = 4'h9;
   localparam logic [3:0] REG_OFFSET  = 4'hA;
   localparam logic [3:0] REG_FOUT    = 4'hB;

   // mode encodings
   localparam logic [1:0] MODE_OFF    = 2'h0;
   localparam logic [1:0] MODE_MASTER = 2'h1;
   localparam logic [1:0] MODE_SLAVE  = 2'h2;

   // ramp times in units of 0.01 s, 1..32000
   localparam logic [15:0] TIME_MIN     = 16'h0001;
   localparam logic [15:0] TIME_MAX     = 16'h7D00;
   localparam logic [15:0] RST_ACCEL    = 16'h01F4;
   localparam logic [15:0] RST_DECEL    = 16'h01F4;
   // percentages in units of 0.01 %, max 50.00 %
   localparam logic [15:0] PCT_MAX      = 16'h1388;
   localparam logic [15:0] RST_AMPL     = 16'h03E8;
   localparam logic [15:0] RST_STEP     = 16'h0001;
   localparam logic [31:0] PCT_FULL     = 32'h0000_2710;
   // frequencies in units of 0.01 Hz
   localparam logic [15:0] RST_REF      = 16'h1388;
   localparam logic [15:0] RST_FMIN     = 16'h0000;
   localparam logic [15:0] RST_FMAX     = 16'hFFFF;
   localparam logic [1:0]  RST_HS_SRC   = 2'h0;

   // one ramp-time unit is 10 ms
   localparam int          TIME_UNIT_NS = 10000000;
   localparam int          CLK_NS       = 4;
   localparam int          TICK_CYC     = TIME_UNIT_NS / CLK_NS;

   localparam int          HS_SOURCES   = 4;

   typedef enum logic [1:0] {ST_IDLE, ST_WAIT_REF, ST_RAMP, ST_HOLD} state_t;

endpackage

// file: src/handshake_sync.sv
`timescale 1ns/100ps
`default_nettype none
module handshake_sync
(
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   input  wire logic [3:0] hs_in,
   input  wire logic [1:0] hs_src,
   output logic            hs_edge
);

   logic [3:0] meta;
   logic [3:0] sync;
   logic       sel_q;
   logic       primed;

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta <= 4'h0;
         sync <= 4'h0;
      end
      else
      begin
         meta <= hs_in;
         sync <= meta;
      end
   end

   // a source swap may read as one edge; swaps only land while stopped
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sel_q   <= 1'b0;
         primed  <= 1'b0;
         hs_edge <= 1'b0;
      end
      else
      begin
         sel_q   <= sync[hs_src];
         primed  <= 1'b1;
         hs_edge <= primed && (sync[hs_src] != sel_q);
      end
   end

endmodule // handshake_sync
`default_nettype wire

// file: verif/traverse_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module traverse_checker
(
   input wire logic        sys_clk,
   input wire logic        rst_b,
   input wire logic [3:0]  addr,
   input wire logic        rd_en,
   input wire logic [15:0] rd_data,
   input wire logic [15:0] ramp_freq,
   input wire logic        hs_out,
   input wire logic [15:0] freq_out,
   input wire logic [17:0] traverse_out,
   input wire logic        active
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // the jump shows on the output one cycle after the toggle
   sequence s_rev;
      $changed(hs_out) && $past(active) ##1 active;
   endsequence
   a_idle_zero: assert property (!active |-> traverse_out == 18'h0)
      else $error("offset not zero while idle");
   a_follow_ref: assert property (!active && $past(rst_b) |->
      freq_out == $past(ramp_freq)) else $error("idle freq wrong");
   a_read_zero: assert property (!$past(rd_en) |-> rd_data == 16'h0)
      else $error("read data outside slot");
   a_read_unmapped: assert property ($past(rd_en) && $past(addr) > 4'hB
      |-> rd_data == 16'h0) else $error("unmapped read not zero");
   a_hs_quiet: assert property ($changed(hs_out) |-> $past(active))
      else $error("handshake moved while idle");
   a_rev_jump: assert property (s_rev |-> ($past(traverse_out[17]) ?
      $signed(traverse_out) > $signed($past(traverse_out)) :
      $signed(traverse_out) < $signed($past(traverse_out))))
      else $error("no jump back at reversal");
   a_start_small: assert property ($rose(active) |->
      traverse_out inside {18'h0, 18'h1, 18'h3FFFF})
      else $error("offset not near zero at start");
   a_zero_offset: assert property (active && traverse_out == 18'h0
      |-> freq_out == $past(ramp_freq)) else $error("sum wrong");
endmodule // traverse_checker
bind traverse_frequency_generator traverse_checker i_traverse_checker
   (.sys_clk(sys_clk), .rst_b(rst_b), .addr(addr), .rd_en(rd_en),
    .rd_data(rd_data), .ramp_freq(ramp_freq), .hs_out(hs_out),
    .freq_out(freq_out), .traverse_out(traverse_out), .active(active));
`default_nettype wire

// file: verif/paired_drive_model.sv
`timescale 1ns/100ps
`default_nettype none
module paired_drive_model
(
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   input  wire logic       run,
   input  wire logic [7:0] half_cyc,
   output logic            hs
);
   logic [7:0] cnt;
   // level flips once per reversal of the far drive
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt <= 8'h00;
         hs  <= 1'b0;
      end
      else if (run && cnt >= half_cyc - 8'h01)
      begin
         cnt <= 8'h00;
         hs  <= ~hs;
      end
      else if (run)
         cnt <= cnt + 8'h01;
   end
endmodule // paired_drive_model
`default_nettype wire

// file: verif/traverse_frequency_generator_bench.sv
`timescale 1ns/100ps
`default_nettype none
module traverse_frequency_generator_bench;
   logic        sys_clk = 0, rst_b = 0, wr_en = 0, rd_en = 0, run = 0;
   logic        hs_out, active, hs, act_m = 0;
   logic [3:0]  addr = 4'h0, noise = 4'h0, hs_in;
   logic [7:0]  half = 8'hC8;
   logic [15:0] wr_data = 16'h0, ramp_freq = 16'h0, rd_data, freq_out;
   logic [17:0] traverse_out;
   logic [31:0] seed = 32'hE2EF;
   int          n_errors = 0, total_checks = 0, regs[16], o, mx, mn, tg, fs;
   always #2 sys_clk = ~sys_clk;
   traverse_frequency_generator #(.tick_cyc(4)) i_traverse_frequency_generator
      (.sys_clk(sys_clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data),
       .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
       .ramp_freq(ramp_freq), .hs_in(hs_in), .hs_out(hs_out),
       .freq_out(freq_out), .traverse_out(traverse_out), .active(active));
   paired_drive_model i_paired_drive_model
      (.sys_clk(sys_clk), .rst_b(rst_b), .run(run), .half_cyc(half), .hs(hs));
   // unselected pins toggle at random so a wrong source pick shows
   assign hs_in = {noise[3], hs, noise[1:0]};
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   always @(posedge sys_clk)
   begin
      seed  <= lfsr(seed);
      noise <= seed[3:0];
   end
   function automatic int fit(input logic [3:0] a, input int d);
      if (a == 4'h0)
         return (d < 3) ? d : regs[0];
      if (a == 4'h1 || a == 4'h2)
         return d < 1 ? 1 : d > 32000 ? 32000 : d;
      if (a == 4'h3 || a == 4'h4)
         return d < 1 ? 1 : d > 5000 ? 5000 : d;
      return d;
   endfunction
   task automatic chk(input string what, input logic [17:0] exp, got);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      if (a == 4'h0 || (!act_m && a < 4'h9))
         regs[a] = fit(a, int'(d));
      @(posedge sys_clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge sys_clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      #1 chk("register", 18'(regs[a]), 18'(rd_data));
   endtask
   task automatic wait_active;
      int k;
      k = 0;
      while (active !== 1'b1 && k < 20)
      begin
         @(posedge sys_clk);
         #1 k++;
      end
      chk("active", 18'h1, 18'(active));
   endtask
   task automatic clr;
      mx = -999;
      mn = 999;
      tg = 0;
      fs = 0;
   endtask
   // reference held at 100, band 95..105, so the sum is easy to predict
   task automatic watch(input int n);
      logic p;
      repeat (n)
      begin
         p = hs_out;
         @(posedge sys_clk);
         #1 o = $signed(traverse_out);
         tg += int'(hs_out !== p);
         if (fs == 0)
            fs = o;
         mx = o > mx ? o : mx;
         mn = o < mn ? o : mn;
         chk("freq", 18'(o + 100 < 95 ? 95 : o + 100 > 105 ? 105 : o + 100),
             18'(freq_out));
      end
   endtask
   initial
   begin
      regs = '{1: 500, 2: 500, 3: 1000, 4: 1, 6: 5000, 8: 65535, default: 0};
      repeat (3) @(posedge sys_clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 16; i++)
         if (i < 9 || i > 11) rd(4'(i));
      wr(4'h1, 16'h0000);
      wr(4'h2, 16'hFFFF);
      wr(4'h3, 16'h1770);
      wr(4'h4, 16'h0000);
      wr(4'h0, 16'h0003);
      wr(4'h0, 16'h0005);
      for (int i = 0; i < 5; i++) rd(4'(i));
      @(posedge sys_clk);
      ramp_freq <= 16'h0032;
      wr(4'h1, 16'h000A);
      wr(4'h2, 16'h000A);
      wr(4'h3, 16'h03E8);
      wr(4'h4, 16'h01F4);
      wr(4'h6, 16'h0064);
      wr(4'h7, 16'h005F);
      wr(4'h8, 16'h0069);
      wr(4'h0, 16'h0001);
      repeat (20) @(posedge sys_clk);
      #1 chk("early start", 18'h0, 18'(active));
      @(posedge sys_clk);
      ramp_freq <= 16'h0064;
      wait_active();
      act_m = 1;
      wr(4'h3, 16'h0001);
      rd(4'h3);
      clr();
      watch(300);
      chk("master first up", 18'h1, 18'(fs > 0));
      chk("master peak", 18'(10), 18'(mx));
      chk("master trough", 18'(-10), 18'(mn));
      chk("master toggles", 18'h1, 18'(tg >= 8));
      wr(4'h0, 16'h0000);
      repeat (3) @(posedge sys_clk);
      act_m = 0;
      wr(4'h5, 16'h0002);
      wr(4'h0, 16'h0002);
      wait_active();
      run <= 1'b1;
      clr();
      watch(150);
      chk("slave first down", 18'h1, 18'(fs < 0));
      chk("slave hold low", 18'(-10), traverse_out);
      watch(100);
      chk("slave hold high", 18'(10), traverse_out);
      half <= 8'h06;
      clr();
      watch(120);
      chk("slave early turn", 18'h1, 18'(mn > -10 && mx <= 10));
      wr(4'h0, 16'h0000);
      repeat (3) @(posedge sys_clk);
      #1 chk("off offset", 18'h0, traverse_out);
      tally_and_finish();
   end
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      n_errors++;
      tally_and_finish();
   end
endmodule // traverse_frequency_generator_bench
`default_nettype wire
